// file: shared/twsf_regs.svh
// Purpose: offsets, bit positions and counts of the two-wire status block
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes: definitions only
`ifndef TWSF_REGS_SVH
`define TWSF_REGS_SVH
// ==========================================================
// register offsets
`define TWSF_OFS_STATUS 8'h00
`define TWSF_OFS_CTRL 8'h04
`define TWSF_OFS_TXH 8'h08
`define TWSF_OFS_RXH 8'h0C
`define TWSF_OFS_IST 8'h10
`define TWSF_OFS_IMASK 8'h14
// ==========================================================
// status bit positions, plus the control enable bit
`define TWSF_B_ACK 15
`define TWSF_B_MASTER_TX_IN_PROGRESS 14
`define TWSF_B_BCL 10
`define TWSF_B_GC 9
`define TWSF_B_A10 8
`define TWSF_B_WCOL 7
`define TWSF_B_OV 6
`define TWSF_B_DA 5
`define TWSF_B_P 4
`define TWSF_B_S 3
`define TWSF_B_RBF 1
`define TWSF_B_TBF 0
`define TWSF_B_ON 15
// ==========================================================
// interrupt event bits
`define TWSF_I_ACK 0
`define TWSF_I_BCL 1
`define TWSF_I_WCOL 2
`define TWSF_I_OV 3
`define TWSF_I_RX 4
`define TWSF_I_STOP 5
`define TWSF_NIRQ 6
// ==========================================================
// counts and reset values
`define TWSF_ACK_RISE 4'h8
`define TWSF_BYTE_RST 8'h00
`define TWSF_WORD_RST 32'h0000_0000
`endif

// file: shared/twsf_pkg.sv
// Purpose: types shared by the two-wire status block
// Assumes: constants live in twsf_regs.svh
// Notes: no imports, use twsf_pkg::name
`include "twsf_regs.svh"
package twsf_pkg;
  // ==========================================================
  // conditioned bus pins
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } twsf_pins_t;
  // ==========================================================
  // state of the pin conditioner
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_old;
    logic sda_old;
    twsf_pins_t ev;
  } twsf_sync_t;
  // ==========================================================
  // state of the core
  typedef enum logic [1:0] {TWSF_IDLE, TWSF_SHIFT, TWSF_ACKSLOT} twsf_tx_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic on;
    logic [7:0] txh;
    logic [7:0] rxh;
    logic tx_buffer_full;
    logic rx_buffer_full;
    logic ack;
    logic master_tx_in_progress;
    logic bus_collision_flag;
    logic gc;
    logic a10;
    logic wcol;
    logic ov;
    logic da;
    logic p;
    logic s;
    twsf_tx_t txs;
    logic [3:0] bitcnt;
    logic ack_smp;
    logic [`TWSF_NIRQ-1:0] ist;
    logic [`TWSF_NIRQ-1:0] imask;
    logic irq;
  } twsf_state_t;
endpackage

// file: hdl/twsf_pin_sync.sv
// Purpose: two-flop sampling of the bus pins, edge and start/stop finding
// Assumes: bus lines are slow against i_clk (400 ns vs 50 ns)
// Notes: edges are taken from the second flop onward only
`timescale 1ns/1ps
`include "twsf_regs.svh"
module twsf_pin_sync (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  output twsf_pkg::twsf_pins_t o_pins
);
  twsf_pkg::twsf_sync_t q, d;

  always_comb begin
    d = q;
    d.scl_sync = {q.scl_sync[0], i_scl};
    d.sda_sync = {q.sda_sync[0], i_sda};
    d.scl_old = q.scl_sync[1];
    d.sda_old = q.sda_sync[1];
    d.ev.scl = q.scl_sync[1];
    d.ev.sda = q.sda_sync[1];
    d.ev.scl_rise = q.scl_sync[1] & ~q.scl_old;
    d.ev.scl_fall = ~q.scl_sync[1] & q.scl_old;
    // data moving while clock stays high marks a frame boundary
    d.ev.start = q.scl_sync[1] & q.scl_old & ~q.sda_sync[1] & q.sda_old;
    d.ev.stop = q.scl_sync[1] & q.scl_old & q.sda_sync[1] & ~q.sda_old;
  end

  // idle bus is high on both lines
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_old: 1'b1, sda_old: 1'b1,
             ev: '{scl: 1'b1, sda: 1'b1, default: 1'b0}};
    end else begin
      q <= d;
    end
  end

  assign o_pins = q.ev;
endmodule

// file: hdl/twsf_core.sv
// Purpose: status flags of a two-wire bus controller with register port
// Assumes: controller events arrive as one-cycle pulses on i_clk
// Notes: bus pins pass twsf_pin_sync before use
`timescale 1ns/1ps
`include "twsf_regs.svh"
// Functional notes
// - ack flag: 1 no ack, at slot end
// - transmit-busy flag spans eight bits plus ack
// - collision flag cleared only by disabling module
// - general call flag set, cleared on stop
// - ten-bit match flag set, cleared on stop
// - write while busy rejected, sets write collision flag
// - overflow when receive register still full
// - data/address flag: address clears, data sets
// - unimplemented status bits read zero
module twsf_core (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_collision,
  input wire logic i_addr_match,
  input wire logic i_gc_match,
  input wire logic i_a10_match,
  input wire logic i_rx_done,
  input wire logic i_rx_is_data,
  input wire logic [7:0] i_rx_byte,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_enable,
  output logic o_tx_active,
  output logic [7:0] o_tx_data
);
  twsf_pkg::twsf_state_t q, d;
  twsf_pkg::twsf_pins_t pins;

  // ==========================================================
  // pin conditioning
  twsf_pin_sync u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_pins(pins)
  );

  // ==========================================================
  // status word
  function automatic logic [31:0] status_word(twsf_pkg::twsf_state_t s);
    logic [31:0] w;
    w = `TWSF_WORD_RST;
    w[`TWSF_B_ACK] = s.ack;
    w[`TWSF_B_MASTER_TX_IN_PROGRESS] = s.master_tx_in_progress;
    w[`TWSF_B_BCL] = s.bus_collision_flag;
    w[`TWSF_B_GC] = s.gc;
    w[`TWSF_B_A10] = s.a10;
    w[`TWSF_B_WCOL] = s.wcol;
    w[`TWSF_B_OV] = s.ov;
    w[`TWSF_B_DA] = s.da;
    w[`TWSF_B_P] = s.p;
    w[`TWSF_B_S] = s.s;
    w[`TWSF_B_RBF] = s.rx_buffer_full;
    w[`TWSF_B_TBF] = s.tx_buffer_full;
    return w;
  endfunction

  function automatic logic hit(logic [7:0] a, logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic busy;
  logic tx_wr;
  logic wcol_ev;
  logic ov_ev;
  logic rx_load;
  logic ack_done;
  logic [`TWSF_NIRQ-1:0] ev;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    busy = q.master_tx_in_progress | q.tx_buffer_full;
    tx_wr = i_wr & hit(i_addr, `TWSF_OFS_TXH);
    wcol_ev = tx_wr & busy;
    ov_ev = i_rx_done & q.rx_buffer_full;
    rx_load = i_rx_done & ~q.rx_buffer_full;
    ack_done = 1'b0;

    // register reads: data stand one cycle only
    d.rdata = `TWSF_WORD_RST;
    if (i_rd) begin
      case (i_addr)
        `TWSF_OFS_STATUS: d.rdata = status_word(q);
        `TWSF_OFS_CTRL: d.rdata[`TWSF_B_ON] = q.on;
        `TWSF_OFS_TXH: d.rdata[7:0] = q.txh;
        `TWSF_OFS_RXH: d.rdata[7:0] = q.rxh;
        `TWSF_OFS_IST: d.rdata[`TWSF_NIRQ-1:0] = q.ist;
        `TWSF_OFS_IMASK: d.rdata[`TWSF_NIRQ-1:0] = q.imask;
        default: d.rdata = `TWSF_WORD_RST;
      endcase
    end
    if (i_rd && hit(i_addr, `TWSF_OFS_RXH)) begin
      d.rx_buffer_full = 1'b0;
    end

    // control and mask writes
    if (i_wr && hit(i_addr, `TWSF_OFS_CTRL)) begin
      d.on = i_wdata[`TWSF_B_ON];
    end
    if (i_wr && hit(i_addr, `TWSF_OFS_IMASK)) begin
      d.imask = i_wdata[`TWSF_NIRQ-1:0];
    end
    // clearable status bits drop when written zero
    if (i_wr && hit(i_addr, `TWSF_OFS_STATUS)) begin
      if (!i_wdata[`TWSF_B_WCOL]) begin
        d.wcol = 1'b0;
      end
      if (!i_wdata[`TWSF_B_OV]) begin
        d.ov = 1'b0;
      end
    end
    if (i_wr && hit(i_addr, `TWSF_OFS_IST)) begin
      d.ist = q.ist & ~i_wdata[`TWSF_NIRQ-1:0];
    end

    // transmit holding register, refused while busy
    if (tx_wr && !busy && q.on) begin
      d.txh = i_wdata[7:0];
      d.tx_buffer_full = 1'b1;
    end

    // master transmit progress
    case (q.txs)
      twsf_pkg::TWSF_IDLE: begin
        if (q.tx_buffer_full && q.on) begin
          d.tx_buffer_full = 1'b0;
          d.master_tx_in_progress = 1'b1;
          d.bitcnt = 4'h0;
          d.txs = twsf_pkg::TWSF_SHIFT;
        end
      end
      twsf_pkg::TWSF_SHIFT: begin
        if (pins.scl_rise) begin
          d.bitcnt = q.bitcnt + 4'h1;
          // ninth rise is the acknowledge bit
          if (q.bitcnt == `TWSF_ACK_RISE) begin
            d.ack_smp = pins.sda;
            d.txs = twsf_pkg::TWSF_ACKSLOT;
          end
        end
      end
      twsf_pkg::TWSF_ACKSLOT: begin
        if (pins.scl_fall) begin
          d.ack = q.ack_smp;
          d.master_tx_in_progress = 1'b0;
          d.txs = twsf_pkg::TWSF_IDLE;
          ack_done = 1'b1;
        end
      end
      default: d.txs = twsf_pkg::TWSF_IDLE;
    endcase

    // frame boundaries
    if (pins.start) begin
      d.s = 1'b1;
      d.p = 1'b0;
    end
    if (pins.stop) begin
      d.p = 1'b1;
      d.s = 1'b0;
      d.gc = 1'b0;
      d.a10 = 1'b0;
    end

    // slave receive side
    if (i_addr_match) begin
      d.da = 1'b0;
    end
    if (i_rx_done && i_rx_is_data) begin
      d.da = 1'b1;
    end
    if (rx_load) begin
      d.rxh = i_rx_byte;
      d.rx_buffer_full = 1'b1;
    end
    // sets come late so they win over any clear in the same cycle, except the disable clear of the collision flag below
    if (i_gc_match) begin
      d.gc = 1'b1;
    end
    if (i_a10_match) begin
      d.a10 = 1'b1;
    end
    if (ov_ev) begin
      d.ov = 1'b1;
    end
    if (wcol_ev) begin
      d.wcol = 1'b1;
    end
    if (i_collision && q.master_tx_in_progress) begin
      d.bus_collision_flag = 1'b1;
    end

    // a disabled module forgets the bus; abort any transfer too
    if (!q.on) begin
      d.bus_collision_flag = 1'b0;
      d.p = 1'b0;
      d.s = 1'b0;
      d.master_tx_in_progress = 1'b0;
      d.tx_buffer_full = 1'b0;
      d.txs = twsf_pkg::TWSF_IDLE;
    end

    ev = '0;
    ev[`TWSF_I_ACK] = ack_done;
    ev[`TWSF_I_BCL] = i_collision & q.master_tx_in_progress;
    ev[`TWSF_I_WCOL] = wcol_ev;
    ev[`TWSF_I_OV] = ov_ev;
    ev[`TWSF_I_RX] = rx_load;
    ev[`TWSF_I_STOP] = pins.stop;
    d.ist = d.ist | ev;
    d.irq = |(d.ist & d.imask);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_irq = q.irq;
  assign o_enable = q.on;
  assign o_tx_active = q.master_tx_in_progress;
  assign o_tx_data = q.txh;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_ack_end;
    q.txs == twsf_pkg::TWSF_ACKSLOT && pins.scl_fall;
  endsequence
  sequence s_tx_begin;
    q.txs == twsf_pkg::TWSF_IDLE && q.tx_buffer_full && q.on;
  endsequence

  a_ack_update: assert property (
    s_ack_end |=> q.ack == $past(q.ack_smp) && !q.master_tx_in_progress)
    else $error("ack flag not updated at slot end");
  a_master_tx_in_progress_hold: assert property (
    s_tx_begin |=> q.master_tx_in_progress && q.txs == twsf_pkg::TWSF_SHIFT
      && q.bitcnt == 4'h0)
    else $error("transmit-busy flag not raised");
  a_bcl_sticky: assert property (
    q.bus_collision_flag && q.on |=> q.bus_collision_flag)
    else $error("collision flag lost while enabled");
  a_gc_stop: assert property (
    pins.stop && !i_gc_match |=> !q.gc)
    else $error("general call flag survived stop");
  a_a10_stop: assert property (
    pins.stop && !i_a10_match |=> !q.a10)
    else $error("ten-bit flag survived stop");
  a_wcol_set: assert property (
    tx_wr && busy |=> q.wcol && q.txh == $past(q.txh))
    else $error("busy write not refused");
  a_ov_set: assert property (
    i_rx_done && q.rx_buffer_full |=> q.ov && q.rxh == $past(q.rxh))
    else $error("overflow not flagged");
  a_da_flag: assert property (
    i_rx_done && i_rx_is_data |=> q.da)
    else $error("data flag not set");
  a_reserved_zero: assert property (
    i_rd && i_addr == `TWSF_OFS_STATUS |=> o_rdata[31:16] == 16'h0000
      && o_rdata[13:11] == 3'h0)
    else $error("reserved status bits not zero");
  a_ps_disable: assert property (
    !q.on |=> !q.p && !q.s)
    else $error("start/stop bits kept while disabled");
  a_rbf_set: assert property (
    i_rx_done && !q.rx_buffer_full |=> q.rx_buffer_full && q.rxh == $past(i_rx_byte))
    else $error("receive buffer full not set");
  a_tbf_load: assert property (
    tx_wr && !busy && q.on |=> q.tx_buffer_full && q.txh == $past(i_wdata[7:0]))
    else $error("transmit holding register not loaded");
  a_bcl_off: assert property (
    !q.on |=> !q.bus_collision_flag)
    else $error("collision flag kept while disabled");
  a_da_addr: assert property (
    i_addr_match && !(i_rx_done && i_rx_is_data) |=> !q.da)
    else $error("data flag not cleared on address match");
endmodule

// file: sim/twsf_bus_peer.sv
// Purpose: far-side bus peer clocking frames and bytes on the lines
// Assumes: lines have pull-ups, 1 means released; 400 ns bit period
// Notes: both lines stand high between frames
`timescale 1ns/1ps
module twsf_bus_peer (
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // ==========================================================
  // frame conditions
  // non-blocking so a change on a clock edge is seen after that edge
  task automatic start_cond();
    o_sda <= 1'b0;
    #200 o_scl <= 1'b0;
  endtask
  task automatic stop_cond();
    o_sda <= 1'b0;
    #200 o_scl <= 1'b1;
    #200 o_sda <= 1'b1;
    #200;
  endtask
  // ==========================================================
  // eight released data bits, then the ack slot
  task automatic byte_ack(input logic nack);
    for (int i = 0; i < 9; i++) begin
      o_sda <= (i == 8) ? nack : 1'b1;
      #200 o_scl <= 1'b1;
      #200 o_scl <= 1'b0;
    end
    // released after the slot: pull-up wins
    o_sda <= 1'b1;
  endtask
endmodule

// file: sim/twsf_core_tb.sv
// Purpose: self-checking bench of the two-wire status block
// Assumes: peer model drives the bus lines
// Notes: event inputs travel as one vector ev
`timescale 1ns/1ps
`include "twsf_regs.svh"
module twsf_core_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] e;
  } twsf_row_t;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  // collision, addr match, general call, ten-bit, rx done
  logic [4:0] ev = 5'h00;
  logic rx_data = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic scl;
  logic sda;
  logic [31:0] o_rdata;
  logic o_irq;
  logic o_enable;
  logic o_tx_active;
  logic [7:0] o_tx_data;
  int n_errors = 0;
  int checks_done = 0;
  twsf_row_t rows [8] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0},
    '{8'h08, 32'h0}, '{8'h0C, 32'h0}, '{8'h10, 32'h0},
    '{8'h14, 32'h0}, '{8'h18, 32'h0}, '{8'hFC, 32'h0}};
  always #25 i_clk = ~i_clk;
  twsf_core i_twsf_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_scl(scl), .i_sda(sda),
    .i_collision(ev[0]), .i_addr_match(ev[1]), .i_gc_match(ev[2]),
    .i_a10_match(ev[3]), .i_rx_done(ev[4]), .i_rx_is_data(rx_data),
    .i_rx_byte(rx_byte), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_enable(o_enable), .o_tx_active(o_tx_active), .o_tx_data(o_tx_data));
  twsf_bus_peer i_twsf_bus_peer (.o_scl(scl), .o_sda(sda));
  // ==========================================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(nm, e, o_rdata & m);
  endtask
  task automatic pulse(input logic [4:0] e);
    @(posedge i_clk);
    ev <= e;
    @(posedge i_clk);
    ev <= 5'h00;
  endtask
  // pin path is four cycles; six leaves margin
  task automatic settle();
    repeat (6) @(posedge i_clk);
  endtask
  task automatic wait_tx(input logic v);
    int k;
    for (k = 0; k < 20 && o_tx_active !== v; k++) @(negedge i_clk);
    if (k == 20) begin
      chk("tx_active", {31'h0, v}, {31'h0, o_tx_active});
      close_out();
    end
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(negedge i_clk);
    chk("outs", 32'h0, {21'h0, o_irq, o_enable, o_tx_active, o_tx_data});
    foreach (rows[i]) rdc("reset", rows[i].a, 32'hFFFF_FFFF, rows[i].e);
  endtask
  task automatic tx_byte(input logic [7:0] b, input logic nack, coll);
    wr(`TWSF_OFS_TXH, {24'h0, b});
    wait_tx(1'b1);
    if (coll) pulse(5'h01);
    i_twsf_bus_peer.byte_ack(nack);
    settle();
  endtask
  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    wr(`TWSF_OFS_CTRL, 32'h0000_8000);
    i_twsf_bus_peer.start_cond();
    settle();
    rdc("start", `TWSF_OFS_STATUS, 32'h18, 32'h08);
    chk("enable", 32'h1, {31'h0, o_enable});
    wr(`TWSF_OFS_TXH, 32'h0000_00A5);
    wr(`TWSF_OFS_TXH, 32'h0000_005A);
    wait_tx(1'b1);
    chk("txh kept", 32'hA5, {24'h0, o_tx_data});
    rdc("busy", `TWSF_OFS_STATUS, 32'h4080, 32'h4080);
    i_twsf_bus_peer.byte_ack(1'b1);
    settle();
    rdc("nack", `TWSF_OFS_STATUS, 32'hFFFF_FFFF, 32'h8088);
    wr(`TWSF_OFS_IMASK, 32'h01);
    @(posedge i_clk);
    @(negedge i_clk);
    chk("irq on", 32'h1, {31'h0, o_irq});
    wr(`TWSF_OFS_IMASK, 32'h00);
    @(posedge i_clk);
    @(negedge i_clk);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    wr(`TWSF_OFS_IMASK, 32'h01);
    wr(`TWSF_OFS_IST, 32'h3F);
    @(posedge i_clk);
    @(negedge i_clk);
    chk("irq clear", 32'h0, {31'h0, o_irq});
    wr(`TWSF_OFS_STATUS, 32'h0);
    tx_byte(8'h3C, 1'b0, 1'b0);
    rdc("ack", `TWSF_OFS_STATUS, 32'hC480, 32'h0);
    tx_byte(8'hC3, 1'b0, 1'b1);
    wr(`TWSF_OFS_STATUS, 32'h0);
    rdc("collision", `TWSF_OFS_STATUS, 32'h0400, 32'h0400);
    pulse(5'h04);
    pulse(5'h08);
    rdc("gc a10", `TWSF_OFS_STATUS, 32'h0300, 32'h0300);
    i_twsf_bus_peer.stop_cond();
    settle();
    rdc("stop", `TWSF_OFS_STATUS, 32'h0718, 32'h0410);
    @(posedge i_clk);
    rx_data <= 1'b1;
    rx_byte <= 8'h3C;
    pulse(5'h10);
    rx_byte <= 8'hC3;
    pulse(5'h10);
    rdc("overflow", `TWSF_OFS_STATUS, 32'h62, 32'h62);
    rdc("rx hold", `TWSF_OFS_RXH, 32'hFF, 32'h3C);
    pulse(5'h02);
    rdc("addr", `TWSF_OFS_STATUS, 32'h62, 32'h40);
    wr(`TWSF_OFS_STATUS, 32'h0);
    rdc("ov clear", `TWSF_OFS_STATUS, 32'hC0, 32'h0);
    wr(`TWSF_OFS_CTRL, 32'h0);
    wr(`TWSF_OFS_CTRL, 32'h0000_8000);
    rdc("reenable", `TWSF_OFS_STATUS, 32'h0418, 32'h0);
    do_reset();
    close_out();
  end
endmodule
